// >>> core/lfs_ctrl.sv
`timescale 1ns/100ps
module lfs_ctrl
  import lfs_pkg::*;
#(
  parameter int RESET_CYC = 125000000,
  parameter int TOGGLE_CYC = 75000000
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             clk_en_i,
  input  wire logic             supply_on_i,
  input  wire logic             supply_off_i,
  input  wire logic             comp_low_ok_i,
  input  wire logic             comp_high_i,
  input  wire logic             demag_detect_in_i,
  input  wire logic             demag_ov_i,
  input  wire logic             cs_limit_i,
  input  wire logic             supply_ov_i,
  input  wire logic             short_det_i,
  input  wire logic             temp_hot_i,
  input  wire logic             temp_cool_i,
  input  wire logic [ON_W-1:0]  comp_level_i,
  input  wire logic             dim_enable_i,
  output logic                  gate_drive_out_o,
  output logic                  comp_precharge_o,
  output logic                  comp_discharge_o,
  output logic                  supply_pulldown_o,
  output logic                  fault_latched_o,
  output logic                  thermal_off_o,
  output logic [1:0]            dim_level_o
);

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  lfs_sync_if #(.N(SYNC_N)) sif ();
  logic [SYNC_N-1:0] raw;
  logic              temp_hot_s1;
  logic              temp_hot_s2;
  logic              temp_cool_s1;
  logic              temp_cool_s2;

  // pack the threshold comparator inputs
  always_comb begin
    raw              = '0;
    raw[F_UV_ON]     = supply_on_i;
    raw[F_UV_OFF]    = supply_off_i;
    raw[F_COMP_LO]   = comp_low_ok_i;
    raw[F_COMP_HI]   = comp_high_i;
    raw[F_DEMAG]     = demag_detect_in_i;
    raw[F_DEMAG_OV]  = demag_ov_i;
    raw[F_CS_LIM]    = cs_limit_i;
    raw[F_VCC_OV]    = supply_ov_i;
    raw[F_SHORT]     = short_det_i;
  end

  lfs_sync #(.N(SYNC_N)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .clk_en_i   (clk_en_i),
    .raw_i      (raw),
    .sync       (sif)
  );

  // thermal flags synchronised here too
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      temp_hot_s1  <= 1'b0;
      temp_hot_s2  <= 1'b0;
      temp_cool_s1 <= 1'b0;
      temp_cool_s2 <= 1'b0;
    end else if (clk_en_i) begin
      temp_hot_s1  <= temp_hot_i;
      temp_hot_s2  <= temp_hot_s1;
      temp_cool_s1 <= temp_cool_i;
      temp_cool_s2 <= temp_cool_s1;
    end
  end

  logic s_on;
  logic s_off;
  logic s_clo;
  logic s_chi;
  logic s_dmg;
  logic s_dov;
  logic s_cs;
  logic s_vov;
  logic s_sc;

  assign s_on  = sif.flag[F_UV_ON];
  assign s_off = sif.flag[F_UV_OFF];
  assign s_clo = sif.flag[F_COMP_LO];
  assign s_chi = sif.flag[F_COMP_HI];
  assign s_dmg = sif.flag[F_DEMAG];
  assign s_dov = sif.flag[F_DEMAG_OV];
  assign s_cs  = sif.flag[F_CS_LIM];
  assign s_vov = sif.flag[F_VCC_OV];
  assign s_sc  = sif.flag[F_SHORT];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    lfs_state_t       fsm;
    logic [CNT_W-1:0] on_cnt;     // cycles within on-period
    logic [CNT_W-1:0] off_cnt;    // cycles since turn-off
    logic [CNT_W-1:0] vov_cnt;    // supply overvoltage persistence
    logic [ON_W-1:0]  on_len;     // held on-time
    logic             dmg_d;      // previous demag level
    logic             gate;
    logic             prechg;
    logic             dischg;
    logic             pulldn;
    logic             latched;
    logic             started;
    logic             hot;
    logic [1:0]       dim;
    logic [31:0]      gap_cnt;    // supply-off duration
    logic             was_off;
    logic             dmg_seen;   // demag ended in this off-period
  } lfs_st_t;

  lfs_st_t st_r;
  lfs_st_t st_nxt;

  logic [CNT_W-1:0] off_len;
  logic             demag_fall;
  logic             blanking;
  logic             cs_end;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    // low-frequency restart period while output is shorted
    off_len    = s_sc ? CNT_W'(SHORT_CYC) : CNT_W'(START_CYC);
    demag_fall = st_r.dmg_d & ~s_dmg;
    blanking   = st_r.on_cnt < CNT_W'(BLANK_CYC);
    cs_end     = s_cs & ~blanking;
    st_nxt.dmg_d = s_dmg;

    // dimming: count supply gaps
    if (s_off) begin
      if (st_r.gap_cnt != 32'(RESET_CYC)) begin
        st_nxt.gap_cnt = st_r.gap_cnt + 32'h00000001;
      end
      st_nxt.was_off = 1'b1;
    end else if (st_r.was_off && s_on) begin
      st_nxt.was_off = 1'b0;
      st_nxt.gap_cnt = '0;
      if (!dim_enable_i || st_r.gap_cnt >= 32'(RESET_CYC)) begin
        st_nxt.dim = DIM_FULL;
      end else if (st_r.gap_cnt <= 32'(TOGGLE_CYC)) begin
        // step 100 -> 50 -> 25, then wrap
        st_nxt.dim = (st_r.dim == DIM_LAST) ? DIM_FULL : st_r.dim + 2'h1;
      end
    end

    // thermal hysteresis, only once started
    if (!st_r.started) begin
      st_nxt.hot = 1'b0;
    end else if (temp_hot_s2) begin
      st_nxt.hot = 1'b1;
    end else if (temp_cool_s2) begin
      st_nxt.hot = 1'b0;
    end

    // supply overvoltage persistence
    if (s_vov) begin
      if (st_r.vov_cnt != CNT_W'(VOVP_CYC)) begin
        st_nxt.vov_cnt = st_r.vov_cnt + CNT_W'(1);
      end
    end else begin
      st_nxt.vov_cnt = '0;
    end

    case (st_r.fsm)
      LFS_IDLE: begin
        st_nxt.gate    = 1'b0;
        st_nxt.started = 1'b0;
        if (s_on) begin
          st_nxt.fsm    = LFS_PRECHG;
          st_nxt.prechg = 1'b1;
          st_nxt.dischg = 1'b0;
        end
      end
      LFS_PRECHG: begin
        if (s_clo) begin
          st_nxt.fsm     = LFS_SETTLE;
          st_nxt.prechg  = 1'b0;
          st_nxt.off_cnt = '0;
        end
      end
      LFS_SETTLE: begin
        st_nxt.off_cnt = st_r.off_cnt + CNT_W'(1);
        if (st_r.off_cnt == CNT_W'(SETTLE_CYC)) begin
          // single starter pulse
          st_nxt.fsm     = LFS_ON;
          st_nxt.gate    = 1'b1;
          st_nxt.on_cnt  = '0;
          st_nxt.on_len  = comp_level_i;
          st_nxt.started = 1'b1;
        end
      end
      LFS_ON: begin
        st_nxt.on_cnt = st_r.on_cnt + CNT_W'(1);
        st_nxt.dmg_seen = 1'b0;
        // pulse may only end outside blanking
        if (!blanking && (cs_end || st_r.hot || s_chi ||
            st_r.on_cnt >= CNT_W'(st_r.on_len) ||
            st_r.on_cnt >= CNT_W'(ONMAX_CYC))) begin
          st_nxt.fsm     = LFS_OFF;
          st_nxt.gate    = 1'b0;
          st_nxt.off_cnt = '0;
        end
      end
      LFS_OFF: begin
        if (st_r.off_cnt != '1) begin
          st_nxt.off_cnt = st_r.off_cnt + CNT_W'(1);
        end
        // an early demag end still allows turn-on once minimum off elapses
        if (demag_fall) begin
          st_nxt.dmg_seen = 1'b1;
        end
        if (s_dov && st_r.off_cnt >= CNT_W'(OVP_BLANK_CYC)) begin
          st_nxt.fsm = LFS_LATCH;
        end else if (!st_r.hot && st_r.off_cnt >= CNT_W'(MIN_OFF_CYC) &&
                     (((demag_fall || st_r.dmg_seen) && !s_sc) ||
                      st_r.off_cnt >= off_len)) begin
          st_nxt.fsm    = LFS_ON;
          st_nxt.gate   = 1'b1;
          st_nxt.on_cnt = '0;
          st_nxt.on_len = comp_level_i;
        end
      end
      LFS_LATCH: begin
        st_nxt.gate = 1'b0;
      end
      default: begin
        st_nxt.fsm  = LFS_IDLE;
        st_nxt.gate = 1'b0;
      end
    endcase

    // latching protections; gate never cut inside blanking
    if (st_r.fsm != LFS_IDLE && !(st_r.fsm == LFS_ON && blanking)) begin
      if (s_chi && st_r.started) begin
        st_nxt.fsm  = LFS_LATCH;
        st_nxt.gate = 1'b0;
      end
      if (st_r.vov_cnt == CNT_W'(VOVP_CYC)) begin
        st_nxt.fsm    = LFS_LATCH;
        st_nxt.gate   = 1'b0;
        st_nxt.pulldn = 1'b1;
      end
    end
    st_nxt.latched = (st_nxt.fsm == LFS_LATCH);

    // undervoltage returns to idle and clears gate, precharge, pulldown and latches; dimming state is kept
    if (s_off && !s_on && st_r.fsm != LFS_IDLE &&
        !(st_r.fsm == LFS_ON && blanking)) begin
      st_nxt.fsm     = LFS_IDLE;
      st_nxt.gate    = 1'b0;
      st_nxt.prechg  = 1'b0;
      st_nxt.dischg  = 1'b1;
      st_nxt.pulldn  = 1'b0;
      st_nxt.latched = 1'b0;
      st_nxt.started = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r        <= '0;
      st_r.fsm    <= LFS_IDLE;
      st_r.dischg <= 1'b1;
      st_r.dim    <= DIM_FULL;
      st_r.gap_cnt <= 32'(RESET_CYC); // first power-up counts as a long gap
    end else if (clk_en_i) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign gate_drive_out_o  = st_r.gate;
  assign comp_precharge_o  = st_r.prechg;
  assign comp_discharge_o  = st_r.dischg;
  assign supply_pulldown_o = st_r.pulldn;
  assign fault_latched_o   = st_r.latched;
  assign thermal_off_o     = st_r.hot;
  assign dim_level_o       = st_r.dim;

endmodule

// >>> core/lfs_pkg.sv
// Behaviour
// - at turn-on, precharge compensation node; one starter pulse after 0.9V and settle.
// - below turn-off level, stop gate pulses and discharge compensation node.
// - new on-period only on demag end, never before 6.4us minimum off time.
// - no demag after minimum off time: self start 140us after last gate pulse.
// - ignore current-limit comparator for 380ns at start of each pulse.
// - gate stays asserted throughout the blanking window, whatever happens.
// - demag input above 3.2V, 1us after turn-off, latches switching off.
// - supply above 24V for 6us stops switching, pulls supply down, latched.
// - on output short circuit, switch at reduced frequency of about 7kHz.
// - compensation above 2.6V turns switch off at once, latched until supply cycles.
// - outside blanking, current sense above 1.8V ends the on-period at once.
// - shut switch off at 150C, keep off until temperature falls to 130C.
// - thermal sensing is used only after start-up has completed.
// - on-time is constant, set from the compensation level, fixed per line cycle; the code reloads it from the compensation level at every turn-on.
// - each counted toggle steps power through 100%, 50%, 25% in order.
// - toggles within the toggle interval keep stepping and wrap 25% back to 100%.
// - mains off longer than reset interval clears the dimming counter to 100%.
package lfs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 50;
  localparam int CLK_PS         = 20000;
  localparam int T_MIN_OFF_NS   = 6400;
  localparam int T_START_NS     = 140000;
  localparam int T_BLANK_NS     = 380;
  localparam int T_OVP_BLANK_NS = 1000;
  localparam int T_VOVP_NS      = 6000;
  localparam int T_SHORT_HZ     = 7000;
  localparam int T_SETTLE_NS    = 10000;
  localparam int T_ONMAX_NS     = 24000;
  // least times round up, longest round down
  localparam int MIN_OFF_CYC    = (T_MIN_OFF_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int START_CYC      = (T_START_NS / 1000) * CLK_MHZ;
  localparam int BLANK_CYC      = (T_BLANK_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int OVP_BLANK_CYC  = (T_OVP_BLANK_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int VOVP_CYC       = (T_VOVP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SHORT_CYC      = (CLK_MHZ * 1000000) / T_SHORT_HZ;
  localparam int SETTLE_CYC     = (T_SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int ONMAX_CYC      = (T_ONMAX_NS / 1000) * CLK_MHZ;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int CNT_W          = 16;
  localparam int ON_W           = 11;
  localparam int SYNC_N         = 9;
  localparam logic [1:0] DIM_FULL = 2'h0;
  localparam logic [1:0] DIM_HALF = 2'h1;
  localparam logic [1:0] DIM_QRTR = 2'h2;
  localparam logic [1:0] DIM_LAST = DIM_QRTR;

  // flag positions in the synchronised vector
  localparam int F_UV_ON = 0;
  localparam int F_UV_OFF = 1;
  localparam int F_COMP_LO = 2;
  localparam int F_COMP_HI = 3;
  localparam int F_DEMAG = 4;
  localparam int F_DEMAG_OV = 5;
  localparam int F_CS_LIM = 6;
  localparam int F_VCC_OV = 7;
  localparam int F_SHORT = 8;

  typedef enum logic [2:0] {
    LFS_IDLE   = 3'b000,
    LFS_PRECHG = 3'b001,
    LFS_SETTLE = 3'b010,
    LFS_ON     = 3'b011,
    LFS_OFF    = 3'b100,
    LFS_LATCH  = 3'b101
  } lfs_state_t;

endpackage

// >>> core/lfs_sync_if.sv
`timescale 1ns/100ps
// synchroniser output carried to the control core
interface lfs_sync_if #(parameter int N = 9);
  logic [N-1:0] flag;
  modport src (output flag);
  modport dst (input  flag);
endinterface

// >>> core/lfs_sync.sv
`timescale 1ns/100ps
module lfs_sync
  import lfs_pkg::*;
#(
  parameter int N = SYNC_N
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         clk_en_i,
  input  wire logic [N-1:0] raw_i,
  lfs_sync_if.src           sync
);

  typedef struct packed {
    logic [N-1:0] stg1;
    logic [N-1:0] stg2;
  } lfs_sync_st_t;

  lfs_sync_st_t st_r;
  lfs_sync_st_t st_nxt;

  // two flops per analog flag
  always_comb begin
    st_nxt      = st_r;
    st_nxt.stg1 = raw_i;
    st_nxt.stg2 = st_r.stg1;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
    end
  end

  assign sync.flag = st_r.stg2;

endmodule

// >>> sim/lfs_ctrl_props.sv
`timescale 1ns/100ps
module lfs_ctrl_props
  import lfs_pkg::*;
#(
  parameter int RESET_CYC  = 125000000,
  parameter int TOGGLE_CYC = 75000000
) (
  input wire logic       core_clk_i,
  input wire logic       rst_b_i,
  input wire logic       supply_on_i,
  input wire logic       supply_off_i,
  input wire logic       cs_limit_i,
  input wire logic       gate_drive_out_o,
  input wire logic       comp_discharge_o,
  input wire logic       supply_pulldown_o,
  input wire logic       fault_latched_o,
  input wire logic       thermal_off_o,
  input wire logic [1:0] dim_level_o
);
  // ----
  // helpers
  // ----
  logic [15:0] on_len_r;
  logic [15:0] off_len_r;
  logic        uv;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // undervoltage at the pins
  assign uv = supply_off_i && !supply_on_i;
  // length of the present gate phase, off count saturates
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      on_len_r  <= 16'h0;
      off_len_r <= 16'hFFFF;
    end else begin
      on_len_r  <= gate_drive_out_o ? on_len_r + 16'h1 : 16'h0;
      off_len_r <= gate_drive_out_o ? 16'h0 : off_len_r + {15'h0, off_len_r != 16'hFFFF};
    end
  end
  // ----
  // properties
  // ----
  AST_BLANK_HOLD: assert property ($fell(gate_drive_out_o) |-> on_len_r >= BLANK_CYC)
    else $error("gate pulse shorter than blanking");
  AST_MIN_OFF: assert property ($rose(gate_drive_out_o) |-> off_len_r >= MIN_OFF_CYC)
    else $error("off time below minimum");
  AST_UV_STOP: assert property (uv[*8] ##1 uv[*8] ##1 uv[*8] |=>
    !gate_drive_out_o && comp_discharge_o) else $error("undervoltage not stopping");
  AST_CS_END: assert property (gate_drive_out_o && on_len_r >= 16'h17 && cs_limit_i
    |-> ##[1:4] !gate_drive_out_o) else $error("current limit ignored");
  AST_FAULT_HOLD: assert property (fault_latched_o && !uv && !$past(uv) && !$past(uv, 2)
    && !$past(uv, 3) |=> fault_latched_o) else $error("fault latch dropped");
  AST_FAULT_OFF: assert property (fault_latched_o && !gate_drive_out_o |=> !gate_drive_out_o)
    else $error("gate on while latched");
  AST_THERM_OFF: assert property (thermal_off_o && !gate_drive_out_o |=> !gate_drive_out_o)
    else $error("gate on while hot");
  AST_PULLDOWN: assert property ($rose(supply_pulldown_o) |-> ##[0:2] fault_latched_o)
    else $error("pulldown without latch");
  AST_DIM_STEP: assert property ($changed(dim_level_o) |-> dim_level_o != 2'h3 &&
    (dim_level_o == DIM_FULL || dim_level_o == $past(dim_level_o) + 2'h1))
    else $error("dimming step out of order");
  COV_CS: cover property (gate_drive_out_o && cs_limit_i && on_len_r > 16'h17);
  COV_FAULT: cover property ($rose(fault_latched_o));
  COV_WRAP: cover property ($past(dim_level_o) == DIM_QRTR && dim_level_o == DIM_FULL);
endmodule

bind lfs_ctrl lfs_ctrl_props #(.RESET_CYC(RESET_CYC), .TOGGLE_CYC(TOGGLE_CYC)) u_props (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .supply_on_i(supply_on_i),
  .supply_off_i(supply_off_i), .cs_limit_i(cs_limit_i), .gate_drive_out_o(gate_drive_out_o),
  .comp_discharge_o(comp_discharge_o), .supply_pulldown_o(supply_pulldown_o),
  .fault_latched_o(fault_latched_o), .thermal_off_o(thermal_off_o), .dim_level_o(dim_level_o));

// >>> sim/lfs_flyback.sv
`timescale 1ns/100ps
module lfs_flyback (
  input  wire logic        core_clk_i,
  input  wire logic        gate_i,
  input  wire logic        no_demag_i,
  input  wire logic [15:0] stroke_i,
  input  wire logic [15:0] cs_at_i,
  output logic             demag_o,
  output logic             cs_o
);
  logic [15:0] on_r  = 16'h0;
  logic [15:0] off_r = 16'hFFFF;
  logic        g;
  // unknown gate before the first reset edge counts as off
  assign g = (gate_i === 1'b1);
  // cycles since the switch turned on or off
  always @(posedge core_clk_i) begin
    on_r  <= g ? on_r + 16'h1 : 16'h0;
    off_r <= g ? 16'h0 : off_r + {15'h0, off_r != 16'hFFFF};
  end
  // primary current ramps, sense trips at cs_at_i
  assign cs_o = g && (on_r >= cs_at_i);
  // secondary stroke, falling edge marks its end
  assign demag_o = !g && !no_demag_i && (off_r < stroke_i);
endmodule

// >>> sim/tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %0d got %0d", nm, e, g); end end
module tb;
  import lfs_pkg::*;
  logic core_clk_i = 0, rst_b_i = 0, s_on = 0, s_off = 1, c_lo = 0, c_hi = 0;
  logic d_ov = 0, s_ov = 0, sh = 0, hot = 0, cool = 1, nod = 0;
  logic ce = 1, dim_en = 1;
  logic [ON_W-1:0] lvl = 11'h064;
  logic [15:0] cs_at = 16'hFFFF, stroke = 16'h0190;
  logic gate, pre, dis, pd, flt, th, dmg, csl;
  logic [1:0] dim;
  logic [1:0] ex[4] = '{DIM_HALF, DIM_QRTR, DIM_FULL, DIM_HALF};
  int lv[2] = '{100, 200};
  int tl[3] = '{5, 320, 5};
  int error_cnt = 0, check_count = 0, n, m;
  always #10 core_clk_i = ~core_clk_i;
  lfs_ctrl #(.RESET_CYC(200), .TOGGLE_CYC(100)) dut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .clk_en_i(ce),
    .supply_on_i(s_on), .supply_off_i(s_off), .comp_low_ok_i(c_lo), .comp_high_i(c_hi),
    .demag_detect_in_i(dmg), .demag_ov_i(d_ov), .cs_limit_i(csl), .supply_ov_i(s_ov),
    .short_det_i(sh), .temp_hot_i(hot), .temp_cool_i(cool), .comp_level_i(lvl),
    .dim_enable_i(dim_en), .gate_drive_out_o(gate), .comp_precharge_o(pre),
    .comp_discharge_o(dis), .supply_pulldown_o(pd), .fault_latched_o(flt),
    .thermal_off_o(th), .dim_level_o(dim));
  lfs_flyback fb (.core_clk_i(core_clk_i), .gate_i(gate), .no_demag_i(nod),
    .stroke_i(stroke), .cs_at_i(cs_at), .demag_o(dmg), .cs_o(csl));
  // ----
  // shared tasks
  // ----
  function automatic logic sg(int i);
    return (i == 0) ? gate : ((i == 1) ? pre : th);
  endfunction
  // bounded wait for a level, n gives cycles spent
  task automatic wt(int i, logic v, int lim);
    n = 0;
    #1;
    while (sg(i) !== v && n < lim) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (n >= lim) `CHK("wait", 1'b1, 1'b0)
  endtask
  // length of the gate phase opposite to v
  task automatic meas(string s, logic v, int lo, int hi);
    wt(0, v, 8000);
    wt(0, !v, 8000);
    wt(0, v, 8000);
    `CHK(s, 1'b1, n >= lo && n <= hi)
  endtask
  // supply gap of k cycles, then power up again
  task automatic gapsup(int k);
    @(posedge core_clk_i);
    s_on  <= 1'b0;
    s_off <= 1'b1;
    c_lo  <= 1'b0;
    repeat (k) @(posedge core_clk_i);
    #1;
    `CHK("uv gate", 1'b0, gate)
    `CHK("uv discharge", 1'b1, dis)
    @(posedge core_clk_i);
    s_off <= 1'b0;
    s_on  <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    c_lo <= 1'b1;
    repeat (20) @(posedge core_clk_i);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_start;
    @(posedge core_clk_i);
    s_on  <= 1'b1;
    s_off <= 1'b0;
    hot   <= 1'b1;
    cool  <= 1'b0;
    wt(1, 1'b1, 10);
    `CHK("sync latency", 1'b1, n == 3)
    repeat (5) @(posedge core_clk_i);
    #1;
    `CHK("gate in precharge", 1'b0, gate)
    `CHK("thermal before start", 1'b0, th)
    @(posedge core_clk_i);
    hot  <= 1'b0;
    cool <= 1'b1;
    c_lo <= 1'b1;
    wt(0, 1'b1, 700);
    `CHK("starter delay", 1'b1, n >= 501 && n <= 510)
  endtask
  task automatic t_pulse;
    meas("demag restart", 1'b1, 400, 406);
    foreach (lv[i]) begin
      @(posedge core_clk_i);
      lvl <= ON_W'(lv[i]);
      meas("on time", 1'b0, lv[i], lv[i] + 2);
    end
    @(posedge core_clk_i);
    stroke <= 16'h0032;
    meas("min off", 1'b1, MIN_OFF_CYC, MIN_OFF_CYC + 6);
    @(posedge core_clk_i);
    cs_at <= 16'h0028;
    meas("cs limit", 1'b0, 40, 46);
    @(posedge core_clk_i);
    cs_at <= 16'h0003;
    meas("blanking", 1'b0, BLANK_CYC, BLANK_CYC + 3);
    @(posedge core_clk_i);
    cs_at <= 16'hFFFF;
  endtask
  task automatic t_timer;
    @(posedge core_clk_i);
    nod <= 1'b1;
    meas("start timer", 1'b1, START_CYC, START_CYC + 6);
    @(posedge core_clk_i);
    nod <= 1'b0;
    sh  <= 1'b1;
    meas("short period", 1'b1, SHORT_CYC, SHORT_CYC + 6);
    @(posedge core_clk_i);
    sh <= 1'b0;
  endtask
  task automatic t_therm;
    @(posedge core_clk_i);
    hot  <= 1'b1;
    cool <= 1'b0;
    repeat (30) @(posedge core_clk_i);
    #1;
    `CHK("hot shutdown", 1'b1, th)
    `CHK("gate off hot", 1'b0, gate)
    @(posedge core_clk_i);
    hot <= 1'b0;
    repeat (400) @(posedge core_clk_i);
    #1;
    `CHK("hysteresis hold", 1'b1, th)
    @(posedge core_clk_i);
    cool <= 1'b1;
    wt(2, 1'b0, 10);
    wt(0, 1'b1, 7100);
  endtask
  task automatic t_dim;
    `CHK("dim power up", DIM_FULL, dim)
    foreach (ex[i]) begin
      gapsup(50);
      `CHK("dim step", ex[i], dim)
    end
    gapsup(300);
    `CHK("dim reset", DIM_FULL, dim)
    gapsup(50);
    `CHK("dim after reset", DIM_HALF, dim)
    @(posedge core_clk_i);
    dim_en <= 1'b0;
    gapsup(50);
    `CHK("dim disabled", DIM_FULL, dim)
    // clock enable low must hold off the starter pulse
    @(posedge core_clk_i);
    dim_en <= 1'b1;
    ce     <= 1'b0;
    repeat (600) @(posedge core_clk_i);
    #1;
    `CHK("frozen gate", 1'b0, gate)
    @(posedge core_clk_i);
    ce <= 1'b1;
  endtask
  task automatic t_fault;
    foreach (tl[i]) begin
      wt(0, 1'b1, 8000);
      wt(0, 1'b0, 1300);
      repeat (60) @(posedge core_clk_i);
      d_ov <= (i == 0);
      s_ov <= (i == 1);
      c_hi <= (i == 2);
      repeat (tl[i]) @(posedge core_clk_i);
      d_ov <= 1'b0;
      s_ov <= 1'b0;
      c_hi <= 1'b0;
      m = 0;
      repeat (7200) begin
        @(posedge core_clk_i);
        #1;
        m += (gate !== 1'b0);
      end
      `CHK("fault latched", 1'b1, flt)
      `CHK("latched off", 0, m)
      `CHK("pulldown", i == 1, pd)
      gapsup(300);
      `CHK("fault cleared", 1'b0, flt)
    end
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    t_start;
    t_pulse;
    t_timer;
    t_therm;
    t_dim;
    t_fault;
    end_of_test;
  end
  // watchdog
  initial begin
    #1500000;
    error_cnt++;
    end_of_test;
  end
endmodule
